// ===== common/scg_regs.vh
// Register map, field positions and reset values for the strap
// capture and general-purpose pin block. Assumes a 32-bit APB slave, word offsets.
`ifndef SCG_REGS_VH
`define SCG_REGS_VH

`define SCG_NPINS          16
`define SCG_OFS_STRAP      12'h000
`define SCG_OFS_DIR        12'h004
`define SCG_OFS_OUT        12'h008
`define SCG_OFS_IN         12'h00c
`define SCG_OFS_RISE_EN    12'h010
`define SCG_OFS_FALL_EN    12'h014
`define SCG_OFS_IRQ_STAT   12'h018
`define SCG_OFS_IRQ_MASK   12'h01c
`define SCG_OFS_DMA_EN     12'h020
`define SCG_OFS_ROUTE      12'h024
`define SCG_OFS_STATUS     12'h028

`define SCG_DIR_RESET      16'h0000
`define SCG_OUT_RESET      16'h0000
`define SCG_PULL_UP        16'h0001
`define SCG_PULL_DOWN      16'hfffe
`define SCG_RIO_MASK       16'h0030

`define SCG_F_ENDIAN       0
`define SCG_F_BOOT_LO      1
`define SCG_F_BOOT_HI      3
`define SCG_F_CFG_LO       4
`define SCG_F_CFG_HI       10
`define SCG_F_PLL_LO       11
`define SCG_F_PLL_HI       13
`define SCG_F_PCIE_LO      14
`define SCG_F_PCIE_HI      15

`define SCG_ST_CAPTURED    0
`define SCG_ST_RELEASED    1

`define SCG_NCORES         4
`define SCG_ROUTE_W        2

`endif

// ===== design/scg_strap_gpio.v
// Strap capture at full-reset release, then general-purpose pin function with
// edge interrupts and DMA events. Assumes APB master on pclk and board pads
// resolved outside from the pad_out / pad_oe / pad_pull signals.
// Straps are only ever taken on a full reset release, never on warm reset.
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ns
`include "scg_regs.vh"

// Function
// - Strap levels on all pins are captured when full reset goes from low to high.
// - After full reset release and successful boot all pins but 4 and 5 become general-purpose pins.
// - Every pin is enabled at power-up and defaults to input with its driver off.
// - Every pin but 4 and 5 can raise an interrupt on irq, a DMA event routed to any core, or both.
// - Straps decode to endian, boot device, device config, PLL or I2C, and PCIe role.
// - Pins 4 and 5 keep the RapidIO identifier function and never become general pins.
// - After boot each pin takes its default state unless software configured it.
// - Pin 0 has a weak pull-up and pins 1 to 15 weak pull-downs as strap defaults.
// - Warm reset alone does not recapture straps and keeps the captured values.
// - Captured straps sit in a readable strap register that survives warm reset.
module scg_strap_gpio (
  input  wire        pclk,               // System clock
  input  wire        presetn,            // Power-on reset, async, low
  input  wire        clk_en,             // Freezes all state when low
  input  wire        full_reset_n,       // Full reset pin, async
  input  wire        warm_reset_n,       // Warm reset, same clock domain
  input  wire        boot_done,          // Boot loader finished, same domain
  input  wire [15:0] pad_in,             // Pin levels, async
  output reg  [15:0] pad_out,            // Pin output values
  output reg  [15:0] pad_oe,             // Pin output enables
  output wire [15:0] pad_pull_up,        // Weak pull-up enables
  output wire [15:0] pad_pull_dn,        // Weak pull-down enables
  output reg         reset_status_out_n, // Low while reset in progress
  output reg         endian_strap,       // High little endian
  output reg  [2:0]  boot_select_strap,  // Boot device
  output reg  [6:0]  dev_cfg_strap,      // Device configuration
  output reg  [2:0]  pll_i2c_strap,      // PLL multiplier or I2C option
  output reg  [1:0]  pcie_role_strap,    // Endpoint or root complex
  output reg  [1:0]  rapidio_id_strap,   // RapidIO identifier, strap copy until hand-over, then live pins
  output reg  [3:0]  dma_event,          // One-cycle event per core
  output wire        irq,                // Level interrupt
  input  wire [11:0] paddr,              // APB address
  input  wire        psel,               // APB select
  input  wire        penable,            // APB enable
  input  wire        pwrite,             // APB direction
  input  wire [31:0] pwdata,             // APB write data
  output wire        pready,             // APB ready
  output reg  [31:0] prdata,             // APB read data
  output wire        pslverr             // APB error
);

  reg  [1:0]  full_sync;
  reg         full_seen;
  reg  [15:0] in_s1;
  reg  [15:0] in_s2;
  reg  [15:0] in_last;
  reg  [15:0] strap;
  reg         captured;
  reg  [1:0]  hs;
  reg  [1:0]  next_hs;
  wire        released;
  wire [15:0] next_pad_out;
  wire [15:0] next_pad_oe;
  reg  [15:0] dir;
  reg  [15:0] outv;
  reg  [15:0] rise_en;
  reg  [15:0] fall_en;
  reg  [15:0] irq_stat;
  reg  [15:0] irq_mask;
  reg  [15:0] dma_en;
  reg  [31:0] route;
  wire [15:0] edge_hit;
  wire [63:0] pin_dma;
  reg  [15:0] next_irq_stat;
  reg  [3:0]  next_dma;
  reg  [31:0] next_prdata;
  integer     i;
  genvar      g;

  // Hand-over states; GPIO survives warm reset on purpose
  localparam [1:0] HS_WAIT = 2'b00;
  localparam [1:0] HS_BOOT = 2'b01;
  localparam [1:0] HS_GPIO = 2'b10;

  wire        wr = psel & penable & pwrite & clk_en;
  wire        rd = psel & ~penable & ~pwrite;
  wire [15:0] gp_pins = ~`SCG_RIO_MASK;
  wire [15:0] gp_live = released ? gp_pins : 16'h0000;

  // One-hot register decode, shared by error and write logic
  function [10:0] reg_sel;
    input [11:0] a;
    begin
      case (a)
        `SCG_OFS_STRAP:    reg_sel = 11'h001;
        `SCG_OFS_DIR:      reg_sel = 11'h002;
        `SCG_OFS_OUT:      reg_sel = 11'h004;
        `SCG_OFS_IN:       reg_sel = 11'h008;
        `SCG_OFS_RISE_EN:  reg_sel = 11'h010;
        `SCG_OFS_FALL_EN:  reg_sel = 11'h020;
        `SCG_OFS_IRQ_STAT: reg_sel = 11'h040;
        `SCG_OFS_IRQ_MASK: reg_sel = 11'h080;
        `SCG_OFS_DMA_EN:   reg_sel = 11'h100;
        `SCG_OFS_ROUTE:    reg_sel = 11'h200;
        `SCG_OFS_STATUS:   reg_sel = 11'h400;
        default:           reg_sel = 11'h000;
      endcase
    end
  endfunction

  // Core number to one-hot event lines
  function [3:0] core_sel;
    input [1:0] c;
    begin
      case (c)
        2'b00:   core_sel = 4'h1;
        2'b01:   core_sel = 4'h2;
        2'b10:   core_sel = 4'h4;
        default: core_sel = 4'h8;
      endcase
    end
  endfunction

  // Unmapped offsets give an error and read zero
  wire [10:0] sel = reg_sel(paddr);

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~(|sel);
  assign irq     = |(irq_stat & irq_mask);

  assign pad_pull_up = `SCG_PULL_UP;
  assign pad_pull_dn = `SCG_PULL_DOWN;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      full_sync <= 2'b00;
      in_s1     <= 16'h0000;
      in_s2     <= 16'h0000;
    end else if (clk_en) begin
      full_sync <= {full_sync[0], full_reset_n};
      in_s1     <= pad_in;
      in_s2     <= in_s1;
    end
  end

  // warm reset never touches the strap copy
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      full_seen <= 1'b0;
      strap     <= 16'h0000;
      captured  <= 1'b0;
    end else if (clk_en) begin
      full_seen <= full_sync[1];
      if (!full_sync[1]) begin
        captured <= 1'b0;
      end else if (!full_seen) begin
        strap    <= in_s2;
        captured <= 1'b1;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      endian_strap      <= 1'b0;
      boot_select_strap <= 3'h0;
      dev_cfg_strap     <= 7'h00;
      pll_i2c_strap     <= 3'h0;
      pcie_role_strap   <= 2'h0;
      rapidio_id_strap  <= 2'h0;
    end else if (clk_en) begin
      endian_strap      <= strap[`SCG_F_ENDIAN];
      boot_select_strap <= strap[`SCG_F_BOOT_HI:`SCG_F_BOOT_LO];
      dev_cfg_strap     <= strap[`SCG_F_CFG_HI:`SCG_F_CFG_LO];
      pll_i2c_strap     <= strap[`SCG_F_PLL_HI:`SCG_F_PLL_LO];
      pcie_role_strap   <= strap[`SCG_F_PCIE_HI:`SCG_F_PCIE_LO];
      // identifier pins follow the live pads once handed over, the strap copy before
      rapidio_id_strap  <= released ? in_s2[5:4] : strap[5:4];
    end
  end

  // hand over after release and boot
  always @* begin
    next_hs = hs;
    case (hs)
      HS_WAIT: begin
        if (full_sync[1] && warm_reset_n && captured) begin
          next_hs = boot_done ? HS_GPIO : HS_BOOT;
        end
      end
      // Warm reset only holds off the boot exit
      HS_BOOT: begin
        if (!full_sync[1]) begin
          next_hs = HS_WAIT;
        end else if (warm_reset_n && boot_done) begin
          next_hs = HS_GPIO;
        end
      end
      // Full reset low always drops back to waiting
      HS_GPIO: begin
        if (!full_sync[1]) begin
          next_hs = HS_WAIT;
        end
      end
      default: next_hs = HS_WAIT;
    endcase
  end

  assign released = (hs == HS_GPIO);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs                 <= HS_WAIT;
      reset_status_out_n <= 1'b0;
    end else if (clk_en) begin
      hs <= next_hs;
      if (!full_sync[1] || !warm_reset_n) begin
        reset_status_out_n <= 1'b0;
      end else begin
        reset_status_out_n <= released;
      end
    end
  end

  generate
    for (g = 0; g < `SCG_NPINS; g = g + 1) begin : g_drive
      assign next_pad_out[g] = outv[g] & gp_live[g];
      assign next_pad_oe[g]  = dir[g] & gp_live[g];
    end
  endgenerate

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_out <= `SCG_OUT_RESET;
      pad_oe  <= `SCG_DIR_RESET;
    end else if (clk_en) begin
      pad_out <= next_pad_out;
      pad_oe  <= next_pad_oe;
    end
  end

  // per-pin edge detect and event routing
  // Edges only count once the pin is handed over
  generate
    for (g = 0; g < `SCG_NPINS; g = g + 1) begin : g_pin
      wire rise_g = in_s2[g] & ~in_last[g] & rise_en[g];
      wire fall_g = ~in_s2[g] & in_last[g] & fall_en[g];
      assign edge_hit[g]       = gp_live[g] & (rise_g | fall_g);
      assign pin_dma[4*g +: 4] = (edge_hit[g] & dma_en[g]) ? core_sel(route[2*g +: 2]) : 4'h0;
    end
  endgenerate

  // status sets win over a same-cycle clear
  always @* begin
    next_irq_stat = irq_stat;
    if (wr && sel[6]) begin
      next_irq_stat = irq_stat & ~pwdata[15:0];
    end
    next_irq_stat = next_irq_stat | edge_hit;
    next_dma      = 4'h0;
    // Several pins may hit one core in a cycle
    for (i = 0; i < `SCG_NPINS; i = i + 1) begin
      next_dma = next_dma | pin_dma[4*i +: 4];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir      <= `SCG_DIR_RESET;
      outv     <= `SCG_OUT_RESET;
      rise_en  <= 16'h0000;
      fall_en  <= 16'h0000;
      irq_stat <= 16'h0000;
      irq_mask <= 16'h0000;
      dma_en   <= 16'h0000;
      route    <= 32'h00000000;
      in_last  <= 16'h0000;
      dma_event <= 4'h0;
    end else if (clk_en) begin
      in_last   <= in_s2;
      irq_stat  <= next_irq_stat;
      dma_event <= next_dma;
      // Identifier pins 4 and 5 can never be set as outputs
      if (wr && sel[1]) begin
        dir <= pwdata[15:0] & gp_pins;
      end
      if (wr && sel[2]) begin
        outv <= pwdata[15:0] & gp_pins;
      end
      if (wr && sel[4]) begin
        rise_en <= pwdata[15:0];
      end
      if (wr && sel[5]) begin
        fall_en <= pwdata[15:0];
      end
      if (wr && sel[7]) begin
        irq_mask <= pwdata[15:0];
      end
      if (wr && sel[8]) begin
        dma_en <= pwdata[15:0];
      end
      if (wr && sel[9]) begin
        route <= pwdata;
      end
    end
  end

  always @* begin
    case (paddr)
      `SCG_OFS_STRAP:    next_prdata = {16'h0000, strap};
      `SCG_OFS_DIR:      next_prdata = {16'h0000, dir};
      `SCG_OFS_OUT:      next_prdata = {16'h0000, outv};
      `SCG_OFS_IN:       next_prdata = {16'h0000, in_s2};
      `SCG_OFS_RISE_EN:  next_prdata = {16'h0000, rise_en};
      `SCG_OFS_FALL_EN:  next_prdata = {16'h0000, fall_en};
      `SCG_OFS_IRQ_STAT: next_prdata = {16'h0000, irq_stat};
      `SCG_OFS_IRQ_MASK: next_prdata = {16'h0000, irq_mask};
      `SCG_OFS_DMA_EN:   next_prdata = {16'h0000, dma_en};
      `SCG_OFS_ROUTE:    next_prdata = route;
      `SCG_OFS_STATUS:   next_prdata = {30'h0, released, captured};
      default:           next_prdata = 32'h00000000;
    endcase
  end

  // Data latched in setup so it stands through the access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (clk_en && rd) begin
      prdata <= next_prdata;
    end
  end

endmodule

// ===== testbench/scg_board_model.sv
// Board side of the strap pins: strap drivers and pad level resolution.
// Assumes the bench decides when the board drives or floats its pins.
`timescale 1ns/1ns
module scg_board_model (
  input  wire [15:0] pad_out,     // Device levels
  input  wire [15:0] pad_oe,      // Device drives
  input  wire [15:0] pad_pull_up, // Device pull-ups
  input  wire [15:0] board_oe,    // Board drives
  input  wire [15:0] board_val,   // Board levels
  output wire [15:0] pad_in       // Resolved pins
);
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & board_oe & board_val)
                | (~pad_oe & ~board_oe & pad_pull_up);
endmodule

// ===== testbench/scg_strap_chk_assertions.sv
// Port checker for strap capture and pin hand-over.
// Assumes one pclk domain with presetn as its reset.
`timescale 1ns/1ns
`include "scg_regs.vh"
module scg_strap_chk (
  input wire        pclk,               // Clock
  input wire        presetn,            // Reset
  input wire        clk_en,             // Run
  input wire        full_reset_n,       // Full reset
  input wire        warm_reset_n,       // Warm reset
  input wire [15:0] pad_in,             // Pins
  input wire [15:0] pad_out,            // Out
  input wire [15:0] pad_oe,             // Enables
  input wire [15:0] pad_pull_up,        // Pull-ups
  input wire [15:0] pad_pull_dn,        // Pull-downs
  input wire        reset_status_out_n, // Status
  input wire        endian_strap,       // Strap
  input wire [2:0]  boot_select_strap,  // Strap
  input wire [6:0]  dev_cfg_strap,      // Strap
  input wire [2:0]  pll_i2c_strap,      // Strap
  input wire [1:0]  pcie_role_strap,    // Strap
  input wire        psel,               // APB
  input wire        penable,            // APB
  input wire [11:0] paddr,              // APB
  input wire        pslverr             // APB
);
  reg         seen_rel;
  wire [15:0] dec = {pcie_role_strap, pll_i2c_strap, dev_cfg_strap,
                     boot_select_strap, endian_strap};
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      seen_rel <= 1'b0;
    else if (reset_status_out_n)
      seen_rel <= 1'b1;
  end
  pulls_fixed_a: assert property (
    pad_pull_up == `SCG_PULL_UP && pad_pull_dn == `SCG_PULL_DOWN) else $error("pulls");
  rio_undriven_a: assert property (
    pad_oe[5:4] == 2'b00 && pad_out[5:4] == 2'b00) else $error("id pins driven");
  oe_off_early_a: assert property (
    !seen_rel |-> pad_oe == 16'h0000 && pad_out == 16'h0000) else $error("early drive");
  strap_capture_a: assert property (
    $rose(full_reset_n) ##0 (clk_en && $stable(pad_in))[*6] |-> dec == pad_in)
    else $error("strap capture");
  strap_hold_a: assert property ($changed(dec) |-> !(&{$past(full_reset_n, 3),
    $past(full_reset_n, 4), $past(full_reset_n, 5), $past(full_reset_n, 6)}))
    else $error("strap changed");
  warm_status_a: assert property (
    !warm_reset_n [*2] |-> !reset_status_out_n) else $error("status high in warm reset");
  err_access_a: assert property (
    pslverr |-> psel && penable) else $error("error outside access");
  unmapped_err_a: assert property (
    psel && penable && paddr > `SCG_OFS_STATUS |-> pslverr) else $error("no error");
  cover property ($rose(full_reset_n));
  cover property ($rose(reset_status_out_n));
  cover property (pslverr);
endmodule
bind scg_strap_gpio scg_strap_chk u_scg_strap_chk (.*);

// ===== testbench/tb_strap_capture_gpio_release.sv
// Self-checking bench: strap capture, warm reset, hand-over, pins, events.
// Assumes the board model resolves pads and APB answers within a few cycles.
`timescale 1ns/1ns
`include "scg_regs.vh"
module tb_strap_capture_gpio_release;
  reg         pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, full_reset_n = 1'b0;
  reg         warm_reset_n = 1'b1, boot_done = 1'b0, psel = 1'b0, penable = 1'b0;
  reg         pwrite = 1'b0, err;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0, rd;
  reg  [15:0] board_oe = 16'h0000, board_val = 16'h0000, s, st;
  reg  [3:0]  ev;
  wire [15:0] pad_in, pad_out, pad_oe, pad_pull_up, pad_pull_dn;
  wire [6:0]  dev_cfg_strap;
  wire [2:0]  boot_select_strap, pll_i2c_strap;
  wire [1:0]  pcie_role_strap, rapidio_id_strap;
  wire [3:0]  dma_event;
  wire [31:0] prdata;
  wire        endian_strap, irq, pready, pslverr, reset_status_out_n;
  wire [15:0] dec = {pcie_role_strap, pll_i2c_strap, dev_cfg_strap,
                     boot_select_strap, endian_strap};
  integer     num_errors = 0, tests_run = 0, i, p, c, n;
  always #5 pclk = ~pclk;
  scg_strap_gpio u_scg_strap_gpio (.*);
  scg_board_model u_scg_board_model (.*);
  function [31:0] gp(input [31:0] v);
    gp = v & ~{16'h0000, `SCG_RIO_MASK};
  endfunction
  task stop_test;
    begin
      $display("errors %0d comparisons %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    integer k;
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      for (k = 0; pready !== 1'b1 && k < 20; k = k + 1)
        @(posedge pclk);
      if (k == 20) begin
        num_errors = num_errors + 1;
        stop_test;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task wait_irq(input lvl);
    begin
      ev = 4'h0;
      for (n = 0; irq !== lvl && n < 20; n = n + 1) begin
        @(posedge pclk);
        ev = ev | dma_event;
      end
      if (n == 20) begin
        num_errors = num_errors + 1;
        stop_test;
      end
      for (n = 0; n < 3; n = n + 1) begin
        @(posedge pclk);
        ev = ev | dma_event;
      end
    end
  endtask
  initial begin
    s = $urandom(32'h4e6b67e3);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 4; i = i + 1) begin
      st = (i == 0) ? 16'h0001 : (i == 1) ? 16'hfffe : $urandom;
      board_oe <= (i == 0) ? 16'h0000 : 16'hffff;
      board_val <= st;
      repeat (3) @(posedge pclk);
      full_reset_n <= 1'b1;
      repeat (6) @(posedge pclk);
      chk(dec, st);
      chk(rapidio_id_strap, st[5:4]);
      apb(1'b0, `SCG_OFS_STRAP, 32'h0);
      chk(rd, st);
      if (i < 3)
        full_reset_n <= 1'b0;
    end
    board_val <= ~st;
    warm_reset_n <= 1'b0;
    repeat (4) @(posedge pclk);
    warm_reset_n <= 1'b1;
    apb(1'b1, `SCG_OFS_STRAP, ~st);
    apb(1'b0, `SCG_OFS_STRAP, 32'h0);
    chk(rd, st);
    chk(dec, st);
    apb(1'b0, `SCG_OFS_STATUS, 32'h0);
    chk(rd, 32'h1);
    boot_done <= 1'b1;
    board_oe <= 16'h0000;
    for (n = 0; reset_status_out_n !== 1'b1 && n < 20; n = n + 1)
      @(posedge pclk);
    chk(reset_status_out_n, 1'b1);
    apb(1'b0, `SCG_OFS_STATUS, 32'h0);
    chk(rd, 32'h3);
    chk(pad_oe, 16'h0000);
    apb(1'b0, `SCG_OFS_DIR, 32'h0);
    chk(rd, `SCG_DIR_RESET);
    s = $urandom;
    apb(1'b1, `SCG_OFS_DIR, 32'hffff);
    apb(1'b1, `SCG_OFS_OUT, s);
    apb(1'b0, `SCG_OFS_DIR, 32'h0);
    chk(rd, gp(32'hffff));
    chk(pad_oe, gp(32'hffff));
    chk(pad_out, gp(s));
    apb(1'b0, `SCG_OFS_IN, 32'h0);
    chk(gp(rd), gp(s));
    apb(1'b1, `SCG_OFS_DIR, 32'h0);
    board_oe <= 16'hffff;
    board_val <= 16'h0000;
    p = 6 + $urandom % 10;
    c = $urandom % 4;
    apb(1'b1, `SCG_OFS_RISE_EN, 1 << p);
    apb(1'b1, `SCG_OFS_IRQ_MASK, 1 << p);
    apb(1'b1, `SCG_OFS_DMA_EN, 1 << p);
    apb(1'b1, `SCG_OFS_ROUTE, c << (2 * p));
    board_val[p] <= 1'b1;
    wait_irq(1'b1);
    chk(ev, 1 << c);
    apb(1'b0, `SCG_OFS_IRQ_STAT, 32'h0);
    chk(rd, 1 << p);
    apb(1'b1, `SCG_OFS_IRQ_STAT, 1 << p);
    wait_irq(1'b0);
    apb(1'b1, `SCG_OFS_IRQ_MASK, 32'h0);
    apb(1'b1, `SCG_OFS_FALL_EN, 1 << p);
    board_val[p] <= 1'b0;
    repeat (8) @(posedge pclk);
    chk(irq, 1'b0);
    apb(1'b0, `SCG_OFS_IRQ_STAT, 32'h0);
    chk(rd, 1 << p);
    apb(1'b0, 12'h030, 32'h0);
    chk({err, rd}, {1'b1, 32'h0});
    stop_test;
  end
endmodule
